// file: common/asp_pkg.sv
// constants and types shared by the serial output port design
// assumes a master clock of 250 MHz; all port timing counts in master cycles
package asp_pkg;

  // master clock
  localparam int CLK_PERIOD_NS = 4;

  // conversion and update timing, in master clock cycles
  localparam int CONVERT_REQUEST_CYC = 1624;
  localparam int CONVERT_REQUEST_CNT_W = 11;
  localparam int FLAG_LEAD_CYC = 2;
  localparam int RELEASE_CYC = 2;

  // select setup a host needs when it ignores the flag
  localparam int HOST_SETUP_NS = 200;
  localparam int HOST_SETUP_CYC = 2 + (HOST_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // word widths and bipolar offsets
  localparam int WORD_W_16 = 16;
  localparam int WORD_W_20 = 20;
  localparam logic [19:0] BIP_OFFSET_16 = 20'h08000;
  localparam logic [19:0] BIP_OFFSET_20 = 20'h80000;

  // mode pin levels as seen by the pad comparators
  localparam logic [1:0] MODE_SELF = 2'h3;
  localparam logic [1:0] MODE_HOST = 2'h0;

  // reset value of the synchronised pin group {select_n, convert, bipolar, mode}
  localparam logic [4:0] PIN_RST = 5'h10;

  typedef enum logic [1:0] {
    ASP_ST_IDLE = 2'b00,
    ASP_ST_LO = 2'b01,
    ASP_ST_HI = 2'b10,
    ASP_ST_HOST = 2'b11
  } asp_state_t;

endpackage

// file: logic/asp_sync2.sv
// two flip-flop level synchroniser
// assumes each bit is a level that is stable for more than one clock
`timescale 1ns/100ps
module asp_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// file: logic/asp_link_edges.sv
// host shift clock domain: turns each rising and falling edge into a toggle
// assumes the host clock gives a few edges while rst_in is high and just after
`timescale 1ns/100ps
module asp_link_edges (
  // link clock and reset from the master domain
  input wire logic link_clk_in,
  input wire logic rst_in,
  // edge toggles
  output logic rise_tgl_out,
  output logic fall_tgl_out
);

  logic link_rst;

  asp_sync2 #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
    .clk_in(link_clk_in),
    .rst_in(1'b0),
    .async_in(rst_in),
    .sync_out(link_rst)
  );

  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      rise_tgl_out <= 1'b0;
    end else begin
      rise_tgl_out <= ~rise_tgl_out;
    end
  end

  always_ff @(negedge link_clk_in) begin
    if (link_rst) begin
      fall_tgl_out <= 1'b0;
    end else begin
      fall_tgl_out <= ~fall_tgl_out;
    end
  end

endmodule

// file: logic/asp_serial_port.sv
// serial output port of a delta-sigma converter: conversion timer, port word,
// self-clocked and host-clocked shifting, new-word flag and sleep
// assumes filter_word_in is valid on the master clock; pins arrive asynchronously
//
// Summary of operation
// - word ready 1624 cycles after conversion start
// - flag high two cycles before update, check
// - overwrite only if empty or deselected
// - flag low once new word loaded
// - mode pin picks self or host clocking
// - self mode drives data and clock
// - pins released two cycles after flag falls
// - msb two cycles, clock rises midway
// - next bit on each falling clock
// - after lsb float pins, flag high
// - late select gives msb within two cycles
// - deselect finishes bit then floats
// - reselect resumes remaining bits before next word
// - host mode: select drives msb out
// - host rise arms, later falls shift
// - fall before arming is ignored
// - fall on lsb floats data, flag high
// - bipolar words get mid-scale offset
// - middle mode level means sleep
`timescale 1ns/100ps
module asp_serial_port #(
  parameter int WORD_W = asp_pkg::WORD_W_16
) (
  // clocks and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic host_sclk_in,
  // converter side
  input wire logic convert_request_in,
  input wire logic bipolar_in,
  input wire logic [WORD_W-1:0] filter_word_in,
  // mode pin comparator levels
  input wire logic [1:0] port_mode_sleep_pin_in,
  // serial port pins
  input wire logic select_n_in,
  output logic new_word_flag_n_out,
  output logic serial_out_out,
  output logic serial_oe_out,
  output logic sclk_out,
  output logic sclk_oe_out,
  // status
  output logic sleep_out
);
  import asp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // constants and width check

  localparam int IDX_W = $clog2(WORD_W);
  localparam logic [IDX_W-1:0] IDX_TOP = IDX_W'(WORD_W - 1);
  localparam logic [WORD_W-1:0] BIP_OFFSET =
    (WORD_W == WORD_W_20) ? BIP_OFFSET_20[WORD_W-1:0] : BIP_OFFSET_16[WORD_W-1:0];
  localparam logic [CONVERT_REQUEST_CNT_W-1:0] CHK_AT = CONVERT_REQUEST_CNT_W'(CONVERT_REQUEST_CYC - 1 - FLAG_LEAD_CYC);
  localparam logic [CONVERT_REQUEST_CNT_W-1:0] UPD_AT = CONVERT_REQUEST_CNT_W'(CONVERT_REQUEST_CYC - 1);
  localparam logic [1:0] LEAD_INIT = 2'(RELEASE_CYC - 1);

  if (WORD_W != WORD_W_16 && WORD_W != WORD_W_20) begin : g_bad_width
    $error("asp_serial_port: WORD_W must be 16 or 20");
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossings

  logic [4:0] pins_s;
  logic [1:0] tgl_s;
  logic rise_tgl;
  logic fall_tgl;
  logic [1:0] tgl_prev_q;

  asp_sync2 #(.W(5), .RST_VAL(PIN_RST)) u_pin_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({select_n_in, convert_request_in, bipolar_in, port_mode_sleep_pin_in}),
    .sync_out(pins_s)
  );

  asp_link_edges u_link (
    .link_clk_in(host_sclk_in),
    .rst_in(rst_in),
    .rise_tgl_out(rise_tgl),
    .fall_tgl_out(fall_tgl)
  );

  asp_sync2 #(.W(2), .RST_VAL(2'h0)) u_tgl_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({rise_tgl, fall_tgl}),
    .sync_out(tgl_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic busy_q, busy_d;
  logic [CONVERT_REQUEST_CNT_W-1:0] cnt_q, cnt_d;
  logic flag_q, flag_d;
  logic ok_q, ok_d;
  logic full_q, full_d;
  logic [WORD_W-1:0] word_q, word_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [1:0] lead_q, lead_d;
  asp_state_t st_q, st_d;
  logic armed_q, armed_d;
  logic sdo_q, sdo_d;
  logic oe_q, oe_d;
  logic sclk_q, sclk_d;
  logic sclk_oe_q, sclk_oe_d;
  logic sleep_q;

  wire cs_n_s = pins_s[4];
  wire convert_request_s = pins_s[3];
  wire bip_s = pins_s[2];
  wire [1:0] mode_s = pins_s[1:0];
  wire mode_self = mode_s == MODE_SELF;
  wire mode_host = mode_s == MODE_HOST;
  wire sleep_w = !mode_self && !mode_host;
  wire rise_ev = tgl_s[1] ^ tgl_prev_q[1];
  wire fall_ev = tgl_s[0] ^ tgl_prev_q[0];

  wire chk_ev = busy_q && !sleep_w && cnt_q == CHK_AT;
  wire upd_ev = busy_q && !sleep_w && cnt_q == UPD_AT;
  wire start_ev = convert_request_s && !sleep_w && (!busy_q || upd_ev);
  wire load_ev = upd_ev && ok_q;
  wire [WORD_W-1:0] fmt_word = bip_s ? filter_word_in + BIP_OFFSET : filter_word_in;
  wire cur_bit = word_q[idx_q];
  wire nxt_bit = word_q[idx_q - 1'b1];
  wire last_bit = idx_q == '0;
  wire can_drive = st_q == ASP_ST_IDLE && full_q && !cs_n_s && lead_q == 2'h0 && !sleep_w;

  ////////////////////////////////////////////////////////////////////////////
  // conversion timer

  always_comb begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    if (start_ev) begin
      busy_d = 1'b1;
      cnt_d = '0;
    end else if (upd_ev) begin
      busy_d = 1'b0;
    end else if (busy_q && !sleep_w) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port word, flag and shifting

  always_comb begin
    flag_d = flag_q;
    ok_d = ok_q;
    full_d = full_q;
    word_d = word_q;
    idx_d = idx_q;
    lead_d = lead_q;
    st_d = st_q;
    armed_d = armed_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    sclk_d = sclk_q;
    if (lead_q != 2'h0) begin
      lead_d = lead_q - 2'h1;
    end
    if (chk_ev) begin
      flag_d = 1'b1;
      ok_d = !full_q || cs_n_s;
    end
    if (load_ev) begin
      word_d = fmt_word;
      full_d = 1'b1;
      idx_d = IDX_TOP;
      lead_d = LEAD_INIT;
      st_d = ASP_ST_IDLE;
      oe_d = 1'b0;
      sclk_d = 1'b0;
      armed_d = 1'b0;
      flag_d = 1'b0;
    end else begin
      unique case (st_q)
        ASP_ST_IDLE: begin
          if (can_drive) begin
            oe_d = 1'b1;
            sdo_d = cur_bit;
            sclk_d = 1'b0;
            armed_d = 1'b0;
            st_d = mode_self ? ASP_ST_LO : ASP_ST_HOST;
          end
        end
        ASP_ST_LO: begin
          sclk_d = 1'b1;
          st_d = ASP_ST_HI;
        end
        ASP_ST_HI: begin
          sclk_d = 1'b0;
          if (last_bit) begin
            oe_d = 1'b0;
            full_d = 1'b0;
            flag_d = 1'b1;
            st_d = ASP_ST_IDLE;
          end else begin
            idx_d = idx_q - 1'b1;
            sdo_d = nxt_bit;
            if (cs_n_s) begin
              oe_d = 1'b0;
              st_d = ASP_ST_IDLE;
            end else begin
              st_d = ASP_ST_LO;
            end
          end
        end
        ASP_ST_HOST: begin
          if (cs_n_s) begin
            oe_d = 1'b0;
            st_d = ASP_ST_IDLE;
          end else begin
            if (rise_ev && !armed_q) begin
              armed_d = 1'b1;
            end
            if (fall_ev && armed_q) begin
              if (last_bit) begin
                oe_d = 1'b0;
                full_d = 1'b0;
                flag_d = 1'b1;
                st_d = ASP_ST_IDLE;
              end else begin
                idx_d = idx_q - 1'b1;
                sdo_d = nxt_bit;
              end
            end
          end
        end
      endcase
    end
    sclk_oe_d = st_d == ASP_ST_LO || st_d == ASP_ST_HI;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      flag_q <= 1'b1;
      ok_q <= 1'b0;
      full_q <= 1'b0;
      word_q <= '0;
      idx_q <= '0;
      lead_q <= 2'h0;
      st_q <= ASP_ST_IDLE;
      armed_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      sclk_q <= 1'b0;
      sclk_oe_q <= 1'b0;
      sleep_q <= 1'b0;
      tgl_prev_q <= 2'h0;
    end else begin
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      flag_q <= flag_d;
      ok_q <= ok_d;
      full_q <= full_d;
      word_q <= word_d;
      idx_q <= idx_d;
      lead_q <= lead_d;
      st_q <= st_d;
      armed_q <= armed_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      sclk_q <= sclk_d;
      sclk_oe_q <= sclk_oe_d;
      sleep_q <= sleep_w;
      tgl_prev_q <= tgl_s;
    end
  end

  assign new_word_flag_n_out = flag_q;
  assign serial_out_out = sdo_q;
  assign serial_oe_out = oe_q;
  assign sclk_out = sclk_q;
  assign sclk_oe_out = sclk_oe_q;
  assign sleep_out = sleep_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [CONVERT_REQUEST_CNT_W-1:0] age_q;
  always_ff @(posedge clk_in) begin
    if (rst_in || start_ev) begin
      age_q <= '0;
    end else if (busy_q && !sleep_w) begin
      age_q <= age_q + 1'b1;
    end
  end

  wire hi_last = st_q == ASP_ST_HI && last_bit;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_flag_fell_selected;
    ($fell(flag_q) && mode_self && !cs_n_s) ##1 !cs_n_s;
  endsequence

  sequence s_msb_half_bits;
    !sclk_q ##1 (sclk_q && $stable(serial_out_out));
  endsequence

  a_update_time:
    assert property (upd_ev |-> age_q == UPD_AT)
      else $error("port update not at end of conversion");
  a_flag_lead:
    assert property (chk_ev |-> ##1 flag_q ##1 (flag_q && upd_ev))
      else $error("flag not high two cycles before update");
  a_keep_word:
    assert property (upd_ev && !ok_q |=> $stable(word_q) && $stable(full_q))
      else $error("busy port was overwritten");
  a_load_word:
    assert property (load_ev |=> !flag_q && full_q && word_q == $past(fmt_word))
      else $error("loaded word or flag wrong");
  a_self_release:
    assert property (s_flag_fell_selected |-> !oe_q ##1 (oe_q && sclk_oe_q))
      else $error("self mode pins not released two cycles after flag");
  a_msb_two_cycles:
    assert property (mode_self && $rose(oe_q) |-> s_msb_half_bits)
      else $error("bit not held two cycles with mid rise");
  a_bit_on_fall:
    assert property (mode_self && $fell(sclk_q) && oe_q |-> serial_out_out == word_q[idx_q])
      else $error("wrong bit after falling shift clock");
  a_self_end:
    assert property (mode_self && hi_last && !load_ev |=> !oe_q && !sclk_oe_q && flag_q)
      else $error("pins not floated or flag not high after last bit");
  a_late_select:
    assert property (mode_self && can_drive && !load_ev |=> oe_q && sclk_oe_q)
      else $error("late select did not present a bit");
  a_pause_bit:
    assert property (st_q == ASP_ST_LO && cs_n_s && !load_ev |=> oe_q && sclk_q ##1 !oe_q)
      else $error("deselect cut a bit short or kept driving");
  a_host_msb:
    assert property (mode_host && can_drive && !load_ev |=> oe_q && !sclk_oe_q)
      else $error("host mode did not drive data on select");
  a_host_unarmed:
    assert property (st_q == ASP_ST_HOST && !armed_q && !cs_n_s && !load_ev |=> $stable(idx_q))
      else $error("shift before arming");
  a_host_last:
    assert property (st_q == ASP_ST_HOST && armed_q && fall_ev && last_bit && !cs_n_s
                     && !load_ev |=> !oe_q && flag_q && !full_q)
      else $error("last host fall did not float data");

endmodule

// file: tb/asp_host_model.sv
// host side model: shift register reading the port in either mode
// assumes the bench drives select and the mode pin itself
`timescale 1ns/100ps
module asp_host_model #(
  parameter int W = 16
) (
  // link clock
  output logic host_sclk_out,
  // port pins
  input wire logic serial_in,
  input wire logic serial_oe_in,
  input wire logic sclk_in,
  input wire logic sclk_oe_in
);
  logic last_q = 1'b0;
  logic line;
  logic [W-1:0] self_word;
  int self_bits = 0;

  initial host_sclk_out = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // a released data pin shows the inverse of its last level
  always @(serial_in or serial_oe_in) begin
    if (serial_oe_in) begin
      last_q = serial_in;
    end
  end
  assign line = serial_oe_in ? serial_in : ~last_q;

  // self-clocked: take each bit on the rising shift clock
  always @(posedge sclk_in) begin
    if (sclk_oe_in) begin
      self_word = {self_word[W-2:0], line};
      self_bits++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // a few link edges while reset is held and just after
  task automatic link_reset(input int n);
    repeat (n) begin
      #3 host_sclk_out = 1'b1;
      #3 host_sclk_out = 1'b0;
    end
  endtask

  task automatic park_high();
    host_sclk_out = 1'b1;
  endtask

  // host-clocked read, clock stands still between frames
  task automatic read_host(input logic pre_high, output logic [W-1:0] word);
    if (pre_high) begin
      #24;
      host_sclk_out = 1'b0;
      #24;
    end
    for (int i = 0; i < W; i++) begin
      host_sclk_out = 1'b1;
      #24;
      word = {word[W-2:0], line};
      host_sclk_out = 1'b0;
      #24;
    end
  endtask
endmodule

// file: tb/asp_serial_port_test.sv
// testbench of the serial output port with a host model on the far side
// assumes 16-bit words and continuous conversions
`timescale 1ns/100ps
module asp_serial_port_test;
  import asp_pkg::*;
  localparam int W = WORD_W_16;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic host_sclk;
  logic convert_request = 1'b0;
  logic bipolar = 1'b0;
  logic [W-1:0] filter_word = '0;
  logic [1:0] mode = MODE_SELF;
  logic select_n = 1'b1;
  logic flag_n, serial_out, serial_out_oe, sclk, sclk_oe, sleep;
  logic [W-1:0] got;
  int errors = 0;
  int checks_done = 0;

  asp_serial_port #(.WORD_W(W)) asp_serial_port_inst (
    .clk_in(clk_in), .rst_in(rst_in), .host_sclk_in(host_sclk),
    .convert_request_in(convert_request), .bipolar_in(bipolar),
    .filter_word_in(filter_word), .port_mode_sleep_pin_in(mode),
    .select_n_in(select_n), .new_word_flag_n_out(flag_n), .serial_out_out(serial_out),
    .serial_oe_out(serial_out_oe), .sclk_out(sclk), .sclk_oe_out(sclk_oe), .sleep_out(sleep)
  );

  asp_host_model #(.W(W)) asp_host_model_inst (
    .host_sclk_out(host_sclk), .serial_in(serial_out), .serial_oe_in(serial_out_oe),
    .sclk_in(sclk), .sclk_oe_in(sclk_oe)
  );

  initial begin
    forever #2 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [W-1:0] act, input logic [W-1:0] exp, input string what);
    checks_done++;
    if (act !== exp) begin
      errors++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, act, exp);
    end
  endtask

  // waits for a flag level, returns the cycles spent
  task automatic wait_flag(input logic lvl, output int n);
    n = 0;
    while (flag_n !== lvl && n < 4000) begin
      @(negedge clk_in);
      n++;
    end
    check(W'(n < 4000), W'(1), "flag wait");
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic self_frame(input logic [W-1:0] word, input logic bip, input logic pause);
    int n;
    logic [W-1:0] exp;
    exp = bip ? word + BIP_OFFSET_16[W-1:0] : word;
    @(posedge clk_in);
    filter_word <= word;
    bipolar <= bip;
    select_n <= 1'b0;
    wait_flag(1'b1, n);
    wait_flag(1'b0, n);
    asp_host_model_inst.self_bits = 0;
    n = 0;
    while (serial_out_oe !== 1'b1 && n < 10) begin
      @(negedge clk_in);
      n++;
    end
    check(W'(n), W'(RELEASE_CYC), "release delay");
    if (pause) begin
      repeat (10) @(posedge clk_in);
      select_n <= 1'b1;
      repeat (12) @(posedge clk_in);
      check(W'({serial_out_oe, sclk_oe}), '0, "float while deselected");
      select_n <= 1'b0;
    end
    wait_flag(1'b1, n);
    check(asp_host_model_inst.self_word, exp, "self word");
    check(W'(asp_host_model_inst.self_bits), W'(W), "bit count");
    check(W'({serial_out_oe, sclk_oe}), '0, "float after lsb");
  endtask

  task automatic self_late(input logic [W-1:0] word);
    int n;
    @(posedge clk_in);
    select_n <= 1'b1;
    filter_word <= word;
    bipolar <= 1'b0;
    wait_flag(1'b1, n);
    wait_flag(1'b0, n);
    asp_host_model_inst.self_bits = 0;
    repeat (10) @(posedge clk_in);
    select_n <= 1'b0;
    n = 0;
    while (serial_out_oe !== 1'b1 && n < 10) begin
      @(negedge clk_in);
      n++;
    end
    check(W'(n <= RELEASE_CYC + 2), W'(1), "late select delay");
    check(W'(serial_out), W'(word[W-1]), "late msb");
    wait_flag(1'b1, n);
    check(asp_host_model_inst.self_word, word, "late word");
  endtask

  task automatic host_refuse(input logic [W-1:0] a, input logic [W-1:0] b);
    int n;
    @(posedge clk_in);
    select_n <= 1'b1;
    mode <= MODE_HOST;
    filter_word <= a;
    asp_host_model_inst.park_high();
    wait_flag(1'b1, n);
    wait_flag(1'b0, n);
    @(posedge clk_in);
    select_n <= 1'b0;
    filter_word <= b;
    wait_flag(1'b1, n);
    check(W'(n), W'(CONVERT_REQUEST_CYC - FLAG_LEAD_CYC), "check lead");
    repeat (8) @(negedge clk_in);
    check(W'({flag_n, serial_out_oe, serial_out}), W'({2'b11, a[W-1]}), "word kept");
    asp_host_model_inst.read_host(1'b1, got);
    check(got, a, "host word");
    check(W'({serial_out_oe, flag_n}), W'(1), "float after host lsb");
  endtask

  task automatic host_plain(input logic [W-1:0] b);
    int n;
    wait_flag(1'b0, n);
    repeat (HOST_SETUP_CYC) @(posedge clk_in);
    check(W'({serial_out_oe, serial_out}), W'({1'b1, b[W-1]}), "msb on select");
    asp_host_model_inst.read_host(1'b0, got);
    check(got, b, "host word");
    check(W'({serial_out_oe, flag_n}), W'(1), "flag after lsb");
  endtask

  task automatic sleep_check();
    for (int i = 1; i < 3; i++) begin
      @(posedge clk_in);
      mode <= 2'(i);
      repeat (6) @(negedge clk_in);
      check(W'(sleep), W'(1), "sleep entered");
      @(posedge clk_in);
      mode <= MODE_HOST;
      repeat (6) @(negedge clk_in);
      check(W'(sleep), '0, "sleep left");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fork
      asp_host_model_inst.link_reset(6);
    join_none
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    convert_request <= 1'b1;
    self_frame(16'ha5c3, 1'b0, 1'b0);
    $display("test self plain done");
    self_frame(16'h1234, 1'b1, 1'b1);
    $display("test self bipolar pause done");
    self_late(16'h3c5a);
    $display("test self late select done");
    host_refuse(16'hc001, 16'h6e97);
    $display("test host refuse done");
    host_plain(16'h6e97);
    $display("test host plain done");
    sleep_check();
    $display("test sleep done");
    close_out();
  end

  initial begin
    #(12 * CONVERT_REQUEST_CYC * CLK_PERIOD_NS);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end
endmodule
